//--- rtl/hts_cmd_port.sv
// I2C target command port: bit sampling on SCL, command decode, conversion timing and result return
`timescale 1ns/100ps
`include "hts_defines.svh"

module hts_cmd_port
	import hts_pkg::*;
#(
	parameter int unsigned CONV_CYCLES = `HTS_CONV_CYC,
	parameter logic [7:0]  FW_REV      = 8'h5a,          // Arbitrary value
	parameter logic [31:0] ID_WORD1    = 32'h0102_0304,  // Arbitrary value
	parameter logic [31:0] ID_WORD2    = 32'h0506_0708   // Arbitrary value
)
(
	// System clock and reset
	input  wire logic        sys_clk_i,
	input  wire logic        rst_b_i,
	// I2C link; scl_i also clocks the bit sampler
	input  wire logic        scl_i,
	output logic             scl_o,
	output logic             scl_oe_o,
	input  wire logic        sda_i,
	output logic             sda_o,
	output logic             sda_oe_o,
	// Address strap
	input  wire logic        address_select_pin_i,
	// Measurement front end
	input  wire logic [15:0] humidity_code_i,
	input  wire logic [15:0] temp_code_i,
	input  wire logic [15:0] aux_code_i,
	output logic             conv_start_o,
	output logic             conv_busy_o,
	output logic [1:0]       conv_kind_o,
	// Configuration towards the analog side
	output logic [7:0]       user1_o,
	output logic [7:0]       user2_o,
	output logic [7:0]       user3_o,
	output logic             dev_reset_o
);

	localparam int         NSYNC  = 4;
	localparam logic [3:0] SY_RST = 4'b0011;

	function automatic logic [7:0] crc8_step(input logic [7:0] crc, input logic [7:0] data);
		logic [7:0] c;
		c = crc ^ data;
		for (int i = 0; i < 8; i++)
			c = c[7] ? ((c << 1) ^ `HTS_CRC_POLY) : (c << 1);
		return c;
	endfunction

	function automatic logic [5:0] coef_idx(input logic [7:0] loc);
		return loc[5:0];
	endfunction

	// Link domain: sample SDA on each SCL rise and flag it with a toggle
	logic lnk_bit_q;
	logic lnk_tog_q;

	always_ff @(posedge scl_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			lnk_bit_q <= 1'b1;
			lnk_tog_q <= 1'b0;
		end
		else
		begin
			lnk_bit_q <= sda_i;
			lnk_tog_q <= ~lnk_tog_q;
		end

	// Synchronisers: bit 0 SCL, 1 SDA, 2 rise toggle, 3 address strap
	logic [NSYNC-1:0] sy_in;
	logic [NSYNC-1:0] sy1_q;
	logic [NSYNC-1:0] sy2_q;
	logic [NSYNC-1:0] sy3_q;
	logic [NSYNC-1:0] filt_q;
	logic [NSYNC-1:0] filt_p_q;

	assign sy_in = {address_select_pin_i, lnk_tog_q, sda_i, scl_i};

	for (genvar g = 0; g < NSYNC; g++)
	begin : g_sync
		always_ff @(posedge sys_clk_i or negedge rst_b_i)
			if (!rst_b_i)
			begin
				sy1_q[g]    <= SY_RST[g];
				sy2_q[g]    <= SY_RST[g];
				sy3_q[g]    <= SY_RST[g];
				filt_q[g]   <= SY_RST[g];
				filt_p_q[g] <= SY_RST[g];
			end
			else
			begin
				sy1_q[g]    <= sy_in[g];
				sy2_q[g]    <= sy1_q[g];
				sy3_q[g]    <= sy2_q[g];
				filt_q[g]   <= (sy2_q[g] == sy3_q[g]) ? sy3_q[g] : filt_q[g];
				filt_p_q[g] <= filt_q[g];
			end
	end

	// Bus events; the sampled bit stays stable from the arrival of its toggle until the next SCL rise
	wire scl_fall  = filt_p_q[0] & ~filt_q[0];
	wire start_evt = filt_q[0] & filt_p_q[0] & filt_p_q[1] & ~filt_q[1];
	wire stop_evt  = filt_q[0] & filt_p_q[0] & ~filt_p_q[1] & filt_q[1];
	wire rise_evt  = filt_q[2] ^ filt_p_q[2];

	hts_state_t  st_q;
	logic [3:0]  cnt_q;
	logic [7:0]  sh_q;
	logic        ack_q;
	logic        rw_q;
	logic        oe_q;
	logic        stretch_pend_q;
	logic        scl_hold_q;
	logic        busy_q;
	logic        hold_q;
	logic [15:0] timer_q;
	hts_meas_t   kind_q;
	logic [1:0]  nbyte_q;
	logic [7:0]  cmd_q;
	logic [7:0]  user1_q;
	logic [7:0]  user2_q;
	logic [7:0]  user3_q;
	logic [7:0]  coef_loc_q;
	logic [7:0]  coef_mem [64];
	logic [15:0] temp_keep_q;
	logic [31:0] tx_word_q;
	logic [2:0]  tx_len_q;
	logic        crc_en_q;
	logic [2:0]  tx_idx_q;
	logic [7:0]  crc_q;
	logic        conv_start_q;
	logic        dev_rst_q;

	wire [7:0]  rx_byte     = {sh_q[6:0], lnk_bit_q};
	wire        byte8       = rise_evt && cnt_q == 4'd7;
	wire        ack9        = rise_evt && cnt_q == 4'd8;
	wire        addr_hit    = rx_byte[7:1] == {`HTS_ADDR_HI, filt_q[3]};                       // RULE_01
	wire        refuse      = rx_byte[0] && busy_q && !hold_q;                                 // RULE_13
	wire        rd_addr_ack = ack9 && st_q == ST_ADDR && ack_q && rw_q;
	wire        wr_done     = ack9 && st_q == ST_WRITE;
	wire        wr_first    = wr_done && nbyte_q == 2'd0;
	wire        wr_second   = wr_done && nbyte_q == 2'd1;
	wire        wr_third    = wr_done && nbyte_q == 2'd2;
	wire        conv_done   = busy_q && timer_q == 16'h0001;

	// Transmit byte: data first, then checksum, then idle ones
	wire [31:0] tx_shift    = tx_word_q << {tx_idx_q[1:0], 3'b000};
	wire [7:0]  cur_byte    = (tx_idx_q < tx_len_q) ? tx_shift[31:24] :
	                          (tx_idx_q == tx_len_q && crc_en_q) ? crc_q : 8'hff;
	wire        cur_bit     = cur_byte[3'd7 - cnt_q[2:0]];

	// Byte level state machine, SDA driver and clock stretch
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			st_q           <= ST_IDLE;
			cnt_q          <= 4'd0;
			sh_q           <= 8'h00;
			ack_q          <= 1'b0;
			rw_q           <= 1'b0;
			oe_q           <= 1'b0;
			stretch_pend_q <= 1'b0;
			scl_hold_q     <= 1'b0;
		end
		else if (start_evt)
		begin
			st_q  <= ST_ADDR;                                                                 // RULE_21
			cnt_q <= 4'd0;
			oe_q  <= 1'b0;
		end
		else if (stop_evt)
		begin
			st_q <= ST_IDLE;
			oe_q <= 1'b0;
		end
		else if (rise_evt && st_q != ST_IDLE)
		begin
			cnt_q <= (cnt_q == 4'd8) ? 4'd0 : cnt_q + 4'd1;
			if (cnt_q != 4'd8)
				sh_q <= rx_byte;
			if (byte8 && st_q == ST_ADDR)
			begin
				ack_q <= addr_hit && !refuse;                                                 // RULE_12
				rw_q  <= lnk_bit_q;
			end
			if (byte8 && st_q == ST_WRITE)
				ack_q <= 1'b1;
			if (rd_addr_ack)
				stretch_pend_q <= busy_q && hold_q;                                           // RULE_12
			if (ack9 && st_q == ST_ADDR)
				st_q <= !ack_q ? ST_IDLE : (rw_q ? ST_READ : ST_WRITE);
			if (ack9 && st_q == ST_READ && lnk_bit_q)
				st_q <= ST_IDLE;                                                              // RULE_15
		end
		else if (scl_fall)
		begin
			stretch_pend_q <= 1'b0;
			if (st_q == ST_READ && cnt_q == 4'd0 && stretch_pend_q && busy_q)
			begin
				scl_hold_q <= 1'b1;
				oe_q       <= 1'b0;
			end
			else if (st_q == ST_READ)
				oe_q <= cnt_q != 4'd8 && !cur_bit;
			else
				oe_q <= cnt_q == 4'd8 && ack_q && st_q != ST_IDLE;
		end
		else if (scl_hold_q && !busy_q)
		begin
			scl_hold_q <= 1'b0;
			oe_q       <= !cur_bit;
		end

	// Measurement decode
	wire [7:0]  wbyte    = sh_q;
	wire        go_rh    = wr_first && (wbyte == `HTS_CMD_RH_HOLD || wbyte == `HTS_CMD_RH_POLL);  // RULE_03
	wire        go_t     = wr_first && (wbyte == `HTS_CMD_T_HOLD || wbyte == `HTS_CMD_T_POLL);    // RULE_04
	wire        go_aux   = wr_first && wbyte == `HTS_CMD_AUX;                                   // RULE_05
	wire        meas_go  = (go_rh || go_t || go_aux) && !busy_q;
	wire        hold_sel = go_aux ? !user2_q[`HTS_AUX_WAIT_BIT] :                               // RULE_14
	                       (wbyte == `HTS_CMD_RH_HOLD || wbyte == `HTS_CMD_T_HOLD);

	// Conversion timer; a measurement command while busy is dropped
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			busy_q       <= 1'b0;
			hold_q       <= 1'b1;
			timer_q      <= 16'h0000;
			kind_q       <= MK_HUM;
			conv_start_q <= 1'b0;
		end
		else
		begin
			conv_start_q <= meas_go;
			if (meas_go)
			begin
				busy_q  <= 1'b1;
				timer_q <= 16'(CONV_CYCLES);
				kind_q  <= go_rh ? MK_HUM : (go_t ? MK_TEMP : MK_AUX);
				hold_q  <= hold_sel;
			end
			else if (conv_done)
				busy_q <= 1'b0;
			else if (busy_q)
				timer_q <= timer_q - 16'h0001;
		end

	// Response loads
	wire        rd_t_prev = wr_first && wbyte == `HTS_CMD_T_PREV;                               // RULE_06
	wire        rd_u1     = wr_first && wbyte == `HTS_CMD_RD_U1;                                // RULE_08
	wire        rd_u2     = wr_first && wbyte == `HTS_CMD_RD_U2;                                // RULE_07
	wire        rd_u3     = wr_first && wbyte == `HTS_CMD_RD_U3;                                // RULE_09
	wire        rd_any    = wr_second && cmd_q == `HTS_CMD_RD_COEF;
	wire        rd_fw     = rd_any && wbyte == `HTS_SUB_FWREV;                                  // RULE_10
	wire        rd_coef   = rd_any && wbyte != `HTS_SUB_FWREV;
	wire        rd_id1    = wr_second && cmd_q == `HTS_CMD_ID1 && wbyte == `HTS_SUB_ID1;         // RULE_11
	wire        rd_id2    = wr_second && cmd_q == `HTS_CMD_ID2 && wbyte == `HTS_SUB_ID2;
	wire        rd_id     = rd_id1 || rd_id2;
	wire [15:0] rh_res    = {humidity_code_i[15:2], `HTS_RH_TAIL};                              // RULE_18
	wire [15:0] t_res     = {temp_code_i[15:2], `HTS_T_TAIL};                                   // RULE_19
	wire [15:0] conv_res  = (kind_q == MK_HUM) ? rh_res : ((kind_q == MK_TEMP) ? t_res : aux_code_i);
	wire [7:0]  byte1     = rd_u1 ? user1_q : (rd_u2 ? user2_q : (rd_u3 ? user3_q :
	                        (rd_fw ? FW_REV : coef_mem[coef_idx(wbyte)])));
	wire        ld_en     = conv_done || rd_t_prev || rd_u1 || rd_u2 || rd_u3 || rd_any || rd_id;
	// Two-byte results sit MSB first in the top half of the word
	wire [31:0] ld_word   = conv_done ? {conv_res, 16'h0000} :                                  // RULE_23
	                        (rd_t_prev ? {temp_keep_q, 16'h0000} :
	                        (rd_id1 ? ID_WORD1 : (rd_id2 ? ID_WORD2 : {byte1, 24'h000000})));
	wire [2:0]  ld_len    = (conv_done || rd_t_prev) ? 3'd2 : (rd_id ? 3'd4 : 3'd1);             // RULE_22
	wire        ld_crc    = (conv_done && kind_q != MK_AUX) || (!conv_done && rd_id);          // RULE_16

	// Command bytes, user registers and response buffer; unknown codes are taken and ignored
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			nbyte_q     <= 2'd0;
			cmd_q       <= 8'h00;
			user1_q     <= `HTS_UREG_RST;
			user2_q     <= `HTS_UREG_RST;
			user3_q     <= `HTS_UREG_RST;
			coef_loc_q  <= 8'h00;
			temp_keep_q <= 16'h0000;
			tx_word_q   <= 32'hffff_ffff;
			tx_len_q    <= 3'd0;
			crc_en_q    <= 1'b0;
			dev_rst_q   <= 1'b0;
		end
		else
		begin
			dev_rst_q <= wr_first && wbyte == `HTS_CMD_RESET;                                 // RULE_11
			if (start_evt)
				nbyte_q <= 2'd0;
			else if (wr_done && nbyte_q != 2'd3)
				nbyte_q <= nbyte_q + 2'd1;
			if (wr_first)
				cmd_q <= wbyte;                                                               // RULE_02
			if (ld_en)
			begin
				tx_word_q <= ld_word;
				tx_len_q  <= ld_len;
				crc_en_q  <= ld_crc;
			end
			if (conv_done && kind_q == MK_HUM)
				temp_keep_q <= t_res;                                                         // RULE_20
			if (wr_first && wbyte == `HTS_CMD_RESET)
			begin
				user1_q <= `HTS_UREG_RST;
				user2_q <= `HTS_UREG_RST;
				user3_q <= `HTS_UREG_RST;
			end
			if (wr_second && cmd_q == `HTS_CMD_WR_U1)
				user1_q <= wbyte;                                                             // RULE_08
			if (wr_second && cmd_q == `HTS_CMD_WR_U2)
				user2_q <= wbyte;                                                             // RULE_07
			if (wr_second && cmd_q == `HTS_CMD_WR_U3)
				user3_q <= wbyte;                                                             // RULE_09
			if (wr_second && cmd_q == `HTS_CMD_WR_COEF)
				coef_loc_q <= wbyte;
		end

	// Coefficient store, erased state all ones
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			for (int i = 0; i < 64; i++)
				coef_mem[i] <= `HTS_COEF_RST;
		end
		else if (wr_third && cmd_q == `HTS_CMD_WR_COEF)
			coef_mem[coef_idx(coef_loc_q)] <= wbyte;                                          // RULE_10

	// Byte pointer and checksum; a fresh read address restarts the response
	always_ff @(posedge sys_clk_i or negedge rst_b_i)
		if (!rst_b_i)
		begin
			tx_idx_q <= 3'd0;
			crc_q    <= `HTS_CRC_INIT;
		end
		else if (rd_addr_ack)
		begin
			tx_idx_q <= 3'd0;
			crc_q    <= `HTS_CRC_INIT;                                                        // RULE_17
		end
		else if (ack9 && st_q == ST_READ)
		begin
			if (tx_idx_q < tx_len_q)
				crc_q <= crc8_step(crc_q, cur_byte);                                          // RULE_17
			if (!lnk_bit_q && tx_idx_q != 3'd7)
				tx_idx_q <= tx_idx_q + 3'd1;                                                  // RULE_15
		end

	assign scl_o        = 1'b0;
	assign scl_oe_o     = scl_hold_q;
	assign sda_o        = 1'b0;
	assign sda_oe_o     = oe_q;
	assign conv_start_o = conv_start_q;
	assign conv_busy_o  = busy_q;
	assign conv_kind_o  = kind_q;
	assign user1_o      = user1_q;
	assign user2_o      = user2_q;
	assign user3_o      = user3_q;
	assign dev_reset_o  = dev_rst_q;

	default clocking cb @(posedge sys_clk_i); endclocking
	default disable iff (!rst_b_i);

	sequence s_read_addr_busy;
		st_q == ST_ADDR && byte8 && addr_hit && lnk_bit_q && busy_q && !hold_q;
	endsequence

	sequence s_hum_done;
		conv_done && kind_q == MK_HUM;
	endsequence

	sequence s_lsb_nacked;
		st_q == ST_READ && ack9 && lnk_bit_q;
	endsequence

	refuse_addr_a: assert property (s_read_addr_busy |=> !ack_q)                              // RULE_13
		else $error("read address acknowledged during refused conversion");
	foreign_addr_a: assert property (st_q == ST_ADDR && byte8 && !addr_hit |=> !ack_q)       // RULE_01
		else $error("foreign address acknowledged");
	own_write_a: assert property (st_q == ST_ADDR && byte8 && addr_hit && !lnk_bit_q |=> ack_q) // RULE_01
		else $error("own write address not acknowledged");
	stretch_end_a: assert property (scl_hold_q && !busy_q |=> !scl_hold_q && sda_oe_o == !$past(cur_bit)) // RULE_12
		else $error("clock stretch outlives conversion");
	rh_tail_a: assert property (s_hum_done |=> tx_word_q[17:16] == `HTS_RH_TAIL && crc_en_q && tx_len_q == 3'd2) // RULE_18
		else $error("humidity result tail or checksum wrong");
	t_tail_a: assert property (conv_done && kind_q == MK_TEMP |=> tx_word_q[17:16] == `HTS_T_TAIL && crc_en_q) // RULE_19
		else $error("temperature result tail wrong");
	keep_temp_a: assert property (s_hum_done |=> temp_keep_q == {$past(temp_code_i[15:2]), `HTS_T_TAIL}) // RULE_20
		else $error("temperature of humidity run not kept");
	prev_temp_a: assert property (rd_t_prev && !conv_done |=> !crc_en_q && tx_word_q[31:16] == $past(temp_keep_q) && $stable(busy_q)) // RULE_06
		else $error("stored temperature read wrong");
	meas_start_a: assert property (go_rh && !busy_q |=> busy_q && kind_q == MK_HUM ##1 timer_q == 16'(CONV_CYCLES) - 16'h0001) // RULE_03
		else $error("humidity conversion not started");
	aux_mode_a: assert property (go_aux && !busy_q |=> hold_q == !$past(user2_q[`HTS_AUX_WAIT_BIT])) // RULE_14
		else $error("auxiliary wait mode not taken from user register 2");
	id_crc_a: assert property (rd_id && !conv_done |=> crc_en_q && tx_len_q == 3'd4)         // RULE_16
		else $error("identification read without checksum");
	lsb_nack_a: assert property (s_lsb_nacked |=> st_q != ST_READ)                             // RULE_15
		else $error("transmit continues after host not-acknowledge");
	restart_a: assert property (start_evt |=> st_q == ST_ADDR && cnt_q == 4'd0)                // RULE_21
		else $error("start condition not taken");
	reg_write_a: assert property (wr_second && cmd_q == `HTS_CMD_WR_U1 |=> user1_q == $past(sh_q)) // RULE_08
		else $error("user register 1 write lost");

endmodule

//--- rtl/hts_defines.svh
// Command codes, address, reset values and timing constants of the humidity sensor command port
// Behaviour
// RULE_01: Answer 7-bit address 100000 plus the address select pin level.
// RULE_02: Host sends only defined command codes; other codes have undefined effect.
// RULE_03: Code e5 measures humidity with stretching; f5 uses address refusal.
// RULE_04: Code e3 measures temperature with stretching; f3 uses address refusal.
// RULE_05: Code ee measures the auxiliary input.
// RULE_06: Code e0 returns the kept temperature, starts nothing, never adds a checksum.
// RULE_07: Code 50 writes user register 2; code 10 reads it.
// RULE_08: Code e6 writes user register 1; code e7 reads it.
// RULE_09: Code 51 writes user register 3; code 11 reads it.
// RULE_10: Code c5 writes a coefficient, 84 reads one, 84 b8 returns firmware revision.
// RULE_11: Codes fa 0f and fc c9 read identification words; fe resets.
// RULE_12: Busy is shown by holding SCL low or by refusing reads.
// RULE_13: In refusal mode the own address is not acknowledged until conversion ends; the code refuses only the read address and acknowledges writes.
// RULE_14: Auxiliary wait mode follows aux_refusal_wait_enable; host avoids humidity then.
// RULE_15: Checksum follows the low result byte only when the host acknowledged it.
// RULE_16: Identification reads always carry a checksum; other non-measurement commands never do.
// RULE_17: Checksum is CRC-8, polynomial x8+x5+x4+1, starting from zero.
// RULE_18: Humidity low byte always ends in 10.
// RULE_19: Temperature low byte always ends in 00.
// RULE_20: Every humidity measurement also keeps a temperature result for later reading.
// RULE_21: A repeated start is accepted even after a stop.
// RULE_22: Register read is command, repeated start, one byte; write is command, byte.
// RULE_23: Results return most significant byte first, then least significant byte.
// RULE_24: In refusal mode the host re-addresses for reading until acknowledged.
`ifndef HTS_DEFINES_SVH
`define HTS_DEFINES_SVH

`define HTS_ADDR_HI       6'h20
`define HTS_CMD_RH_HOLD   8'he5
`define HTS_CMD_RH_POLL   8'hf5
`define HTS_CMD_T_HOLD    8'he3
`define HTS_CMD_T_POLL    8'hf3
`define HTS_CMD_AUX       8'hee
`define HTS_CMD_T_PREV    8'he0
`define HTS_CMD_RESET     8'hfe
`define HTS_CMD_WR_U2     8'h50
`define HTS_CMD_RD_U2     8'h10
`define HTS_CMD_WR_U1     8'he6
`define HTS_CMD_RD_U1     8'he7
`define HTS_CMD_WR_U3     8'h51
`define HTS_CMD_RD_U3     8'h11
`define HTS_CMD_WR_COEF   8'hc5
`define HTS_CMD_RD_COEF   8'h84
`define HTS_SUB_FWREV     8'hb8
`define HTS_CMD_ID1       8'hfa
`define HTS_SUB_ID1       8'h0f
`define HTS_CMD_ID2       8'hfc
`define HTS_SUB_ID2       8'hc9

`define HTS_CRC_POLY      8'h31
`define HTS_CRC_INIT      8'h00
`define HTS_RH_TAIL       2'b10
`define HTS_T_TAIL        2'b00
`define HTS_AUX_WAIT_BIT  6
`define HTS_UREG_RST      8'h00
`define HTS_COEF_RST      8'hff

`define HTS_CLK_MHZ       200
`define HTS_CONV_NS       10000
`define HTS_CONV_CYC      ((`HTS_CONV_NS * `HTS_CLK_MHZ + 999) / 1000)

`endif

//--- rtl/hts_pkg.sv
// Types shared by the humidity sensor command port
package hts_pkg;

	typedef enum logic [1:0] {
		ST_IDLE  = 2'b00,
		ST_ADDR  = 2'b01,
		ST_WRITE = 2'b11,
		ST_READ  = 2'b10
	} hts_state_t;

	typedef enum logic [1:0] {
		MK_HUM  = 2'b00,
		MK_TEMP = 2'b01,
		MK_AUX  = 2'b11
	} hts_meas_t;

endpackage

//--- tb/hts_host.sv
// I2C host model: open-drain SCL and SDA with an 80 ns bit clock, reports every byte it reads
`timescale 1ns/100ps

module hts_host (
	// Device pin levels and pull-down enables
	input  wire logic       scl_dev_i,
	input  wire logic       sda_dev_i,
	input  wire logic       scl_oe_i,
	input  wire logic       sda_oe_i,
	// Resolved bus levels
	output logic            scl_o,
	output logic            sda_o,
	// Received bytes
	output logic [7:0]      rx_byte_o = 8'h00,
	output logic            rx_tgl_o  = 1'b0
);
	logic scl_low_q = 1'b0;
	logic sda_low_q = 1'b0;
	logic in_frame  = 1'b0;

	// Both lines have pull-ups, so a released line reads high
	assign scl_o = !scl_low_q && !(scl_oe_i && !scl_dev_i);
	assign sda_o = !sda_low_q && !(sda_oe_i && !sda_dev_i);

	// Waits out a stretch, bounded so a stuck device cannot hang the run
	task automatic rise();
		scl_low_q = 1'b0;
		for (int n = 0; n < 4000 && scl_o !== 1'b1; n++)
			#5;
		#40;
	endtask

	task automatic bit_io(input logic b, output logic s);
		scl_low_q = 1'b1;
		#20 sda_low_q = !b;
		#20 rise();
		s = sda_o;
	endtask

	task automatic start();
		if (in_frame)
		begin
			scl_low_q = 1'b1;
			#20 sda_low_q = 1'b0;
			#20 rise();
		end
		else
			#1.3; // Keeps host edges off the system clock edges
		in_frame = 1'b1;
		sda_low_q = 1'b1;
		#40 scl_low_q = 1'b1;
	endtask

	task automatic stop();
		scl_low_q = 1'b1;
		#20 sda_low_q = 1'b1;
		#20 rise();
		sda_low_q = 1'b0;
		#40 in_frame = 1'b0;
	endtask

	task automatic wr_byte(input logic [7:0] d, output logic ack);
		logic s;
		for (int i = 7; i >= 0; i--)
			bit_io(d[i], s);
		bit_io(1'b1, s);
		ack = !s;
	endtask

	task automatic rd_byte(input logic ack, output logic [7:0] d);
		logic s;
		for (int i = 7; i >= 0; i--)
		begin
			bit_io(1'b1, s);
			d[i] = s;
		end
		bit_io(!ack, s);
		rx_byte_o = d;
		rx_tgl_o = !rx_tgl_o;
	endtask
endmodule

//--- tb/tb.sv
// Self-checking bench for the humidity sensor command port
`timescale 1ns/100ps
`include "hts_defines.svh"

module tb
	import hts_pkg::*;
;
	localparam int unsigned CONV = 400;
	localparam logic [7:0]  FW   = 8'h3c;         // Arbitrary value
	localparam logic [31:0] ID1  = 32'h1234_5678; // Arbitrary value
	localparam logic [31:0] ID2  = 32'h9abc_def0; // Arbitrary value
	localparam logic [23:0] WCMD = {`HTS_CMD_WR_U3, `HTS_CMD_WR_U2, `HTS_CMD_WR_U1};
	localparam logic [23:0] RCMD = {`HTS_CMD_RD_U3, `HTS_CMD_RD_U2, `HTS_CMD_RD_U1};
	localparam logic [31:0] MCMD = {`HTS_CMD_T_POLL, `HTS_CMD_T_HOLD, `HTS_CMD_RH_POLL, `HTS_CMD_RH_HOLD};
	localparam logic [31:0] ICMD = {`HTS_CMD_ID2, `HTS_SUB_ID2, `HTS_CMD_ID1, `HTS_SUB_ID1};

	logic        sys_clk, rst_b, strap, scl, sda, scl_oe, sda_oe, start_p, busy, dev_rst, rx_tgl;
	logic        scl_dev, sda_dev;
	logic [1:0]  kind;
	hts_meas_t   exp_kind;
	logic [15:0] hum, tmp, aux, last_t;
	logic [7:0]  u1, u2, u3, rx_byte;
	logic [7:0]  exp_q[$];
	int          miscompares, check_count, cycles, starts, resets;
	wire  [6:0]  ra = {`HTS_ADDR_HI, strap};

	hts_cmd_port #(.CONV_CYCLES(CONV), .FW_REV(FW), .ID_WORD1(ID1), .ID_WORD2(ID2)) i_hts_cmd_port (
		.sys_clk_i(sys_clk), .rst_b_i(rst_b), .scl_i(scl), .scl_o(scl_dev), .scl_oe_o(scl_oe),
		.sda_i(sda), .sda_o(sda_dev), .sda_oe_o(sda_oe), .address_select_pin_i(strap),
		.humidity_code_i(hum), .temp_code_i(tmp), .aux_code_i(aux), .conv_start_o(start_p),
		.conv_busy_o(busy), .conv_kind_o(kind), .user1_o(u1), .user2_o(u2), .user3_o(u3),
		.dev_reset_o(dev_rst));
	hts_host i_hts_host (.scl_dev_i(scl_dev), .sda_dev_i(sda_dev), .scl_oe_i(scl_oe), .sda_oe_i(sda_oe),
		.scl_o(scl), .sda_o(sda),
		.rx_byte_o(rx_byte), .rx_tgl_o(rx_tgl));

	task automatic results();
		$display("Comparisons %0d, mismatches %0d", check_count, miscompares);
		if (miscompares == 0 && check_count > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask

	task automatic chk(input logic [7:0] seen, input logic [7:0] expv);
		check_count++;
		if (seen !== expv)
		begin
			miscompares++;
			$display("Error at %0t: seen %h expected %h", $time, seen, expv);
		end
	endtask

	function automatic logic [7:0] crc8(input logic [7:0] b[$]);
		logic [7:0] c;
		c = `HTS_CRC_INIT;
		foreach (b[i])
			for (int k = 7; k >= 0; k--)
				c = {c[6:0], 1'b0} ^ ((c[7] ^ b[i][k]) ? `HTS_CRC_POLY : 8'h00);
		return c;
	endfunction

	task automatic send(input logic [7:0] b, input logic ok);
		logic a;
		i_hts_host.wr_byte(b, a);
		chk({7'h00, a}, {7'h00, ok});
	endtask

	task automatic wr(input logic [7:0] q[$], input logic stp);
		i_hts_host.start();
		send({ra, 1'b0}, 1'b1);
		foreach (q[i])
			send(q[i], 1'b1);
		if (stp)
			i_hts_host.stop();
	endtask

	// Command then n read bytes; in poll mode the first read address must be refused
	task automatic xfer(input logic [7:0] q[$], input logic poll, input int n);
		logic a;
		logic [7:0] d;
		wr(q, poll);
		i_hts_host.start();
		send({ra, 1'b1}, !poll);
		a = !poll;
		for (int k = 0; k < 20 && !a; k++)
		begin
			i_hts_host.stop();
			i_hts_host.start();
			i_hts_host.wr_byte({ra, 1'b1}, a);
		end
		for (int i = 1; i <= n; i++)
			i_hts_host.rd_byte(i < n, d);
		i_hts_host.stop();
	endtask

	initial
	begin
		sys_clk = 1'b0;
		forever
			#2.5 sys_clk = ~sys_clk;
	end

	always @(posedge sys_clk)
	begin
		cycles++;
		starts += int'(start_p === 1'b1);
		resets += int'(dev_rst === 1'b1);
		if (start_p === 1'b1)
			chk({6'h00, kind}, {6'h00, exp_kind});
		if (cycles == 60000)
		begin
			miscompares++;
			results();
		end
	end

	// Skips the host's settling event at time zero
	always @(rx_tgl)
		if (rst_b === 1'b1)
			chk(rx_byte, exp_q.size() > 0 ? exp_q.pop_front() : 8'hxx);

	initial
	begin
		logic [7:0]  v;
		logic [7:0]  loc;
		logic [15:0] r;
		logic [31:0] w;
		void'($urandom(32'hf3a933d7));
		rst_b = 1'b0;
		strap = 1'($urandom);
		{hum, tmp, aux} = 48'h0;
		exp_kind = MK_HUM;
		repeat (8) @(posedge sys_clk);
		#1 rst_b = 1'b1;
		repeat (8) @(posedge sys_clk);
		chk(u1 | u2 | u3 | {7'h00, busy}, `HTS_UREG_RST);
		for (int i = 0; i < 2; i++)
		begin
			i_hts_host.start();
			send(i ? {`HTS_ADDR_HI, !strap, 1'b0} : {`HTS_ADDR_HI ^ 6'h10, strap, 1'b0}, 1'b0);
			i_hts_host.stop();
		end
		for (int i = 0; i < 3; i++)
		begin
			v = 8'($urandom);
			wr('{WCMD[8*i +: 8], v}, 1'b1);
			repeat (8) @(posedge sys_clk);
			chk(i == 0 ? u1 : i == 1 ? u2 : u3, v);
			exp_q.push_back(v);
			xfer('{RCMD[8*i +: 8]}, 1'b0, 1);
		end
		wr('{`HTS_CMD_RESET}, 1'b1);
		repeat (8) @(posedge sys_clk);
		chk(u1 | u2 | u3, `HTS_UREG_RST);
		chk(8'(resets), 8'h01);
		for (int i = 0; i < 4; i++)
		begin
			@(posedge sys_clk);
			#1 hum = 16'($urandom);
			tmp = 16'($urandom);
			exp_kind = i < 2 ? MK_HUM : MK_TEMP;
			r = i < 2 ? {hum[15:2], `HTS_RH_TAIL} : {tmp[15:2], `HTS_T_TAIL};
			if (i < 2)
				last_t = {tmp[15:2], `HTS_T_TAIL};
			exp_q.push_back(r[15:8]);
			exp_q.push_back(r[7:0]);
			if (i == 0 || i == 3)
				exp_q.push_back(crc8('{r[15:8], r[7:0]}));
			xfer('{MCMD[8*i +: 8]}, i[0], i == 0 || i == 3 ? 3 : 2);
		end
		exp_q.push_back(last_t[15:8]);
		exp_q.push_back(last_t[7:0]);
		exp_q.push_back(8'hff);
		xfer('{`HTS_CMD_T_PREV}, 1'b0, 3);
		for (int i = 0; i < 2; i++)
		begin
			wr('{`HTS_CMD_WR_U2, i ? 8'h00 : 8'h01 << `HTS_AUX_WAIT_BIT}, 1'b1);
			@(posedge sys_clk);
			#1 aux = 16'($urandom);
			exp_kind = MK_AUX;
			exp_q.push_back(aux[15:8]);
			exp_q.push_back(aux[7:0]);
			exp_q.push_back(8'hff);
			xfer('{`HTS_CMD_AUX}, !i[0], 3);
		end
		chk(8'(starts), 8'h06);
		v = 8'($urandom);
		loc = {2'b10, 6'($urandom)};
		// Location b8 after 84 selects the firmware revision instead
		if (loc == `HTS_SUB_FWREV)
			loc = loc ^ 8'h01;
		wr('{`HTS_CMD_WR_COEF, loc, v}, 1'b1);
		exp_q.push_back(v);
		xfer('{`HTS_CMD_RD_COEF, loc}, 1'b0, 1);
		exp_q.push_back(FW);
		xfer('{`HTS_CMD_RD_COEF, `HTS_SUB_FWREV}, 1'b0, 1);
		for (int i = 0; i < 2; i++)
		begin
			w = i ? ID2 : ID1;
			for (int k = 3; k >= 0; k--)
				exp_q.push_back(w[8*k +: 8]);
			exp_q.push_back(crc8('{w[31:24], w[23:16], w[15:8], w[7:0]}));
			xfer('{ICMD[16*i+8 +: 8], ICMD[16*i +: 8]}, 1'b0, 5);
		end
		repeat (20) @(posedge sys_clk);
		chk(8'(exp_q.size()), 8'h00);
		results();
	end
endmodule
